// ---- rtl/svs_cfg.svh ----
// Register offsets, field positions, reset values and timing counts of the supply monitor
`ifndef SVS_CFG_SVH
`define SVS_CFG_SVH
`define SVS_CTRL_OFF      12'h000
`define SVS_MODE_OFF      12'h004
`define SVS_IRQ_STAT_OFF  12'h008
`define SVS_IRQ_EN_OFF    12'h00c
`define SVS_IRQ_CLR_OFF   12'h010
`define SVS_CTRL_EN_BIT   8
`define SVS_CTRL_UV_BIT   9
`define SVS_CTRL_RV_BIT   10
`define SVS_LEVEL_W       4
`define SVS_MODE_SS_BIT   8
`define SVS_MODE_RM_LSB   9
`define SVS_RESET_VAL     32'h0000_0000
`define SVS_READY_TICKS   4
`define SVS_SAMPLE_TICKS  2
`define SVS_RELEASE_CYC   128
`define SVS_IRQ_W         3
`define SVS_IRQ_UV_FALL   0
`define SVS_IRQ_UV_RISE   1
`define SVS_IRQ_READY     2
`endif

// ---- rtl/svs_pkg.sv ----
// Types shared by the supply monitor design
package svs_pkg;
    typedef enum logic [1:0]
    {
        SVS_OFF,
        SVS_SETTLE,
        SVS_JUDGE
    } svs_state_t;
    typedef enum logic [1:0]
    {
        SVS_ACT_NONE  = 2'h0,
        SVS_ACT_RST_A = 2'h1,
        SVS_ACT_IRQ   = 2'h2,
        SVS_ACT_RST_B = 2'h3
    } svs_action_t;
endpackage

// ---- rtl/svs_sync.sv ----
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module svs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1; // Metastable stage, read only by stage two
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync;

    // Next values are just the shift
    always_comb
    begin
        next_stage1 = async_i;
        next_sync   = stage1;
    end

    // Both stages reset to zero
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            stage1 <= '0;
            sync_o <= '0;
        end
        else
        begin
            stage1 <= next_stage1;
            sync_o <= next_sync;
        end
    end
endmodule

// ---- rtl/svs_monitor.sv ----
// Supply monitor supervisor control with AXI4-Lite registers
//
// What this block does
// - Enable with mode 10/11 starts supervision
// - Flag and reset masked until ready
// - Ready after 4 ticks, plus 2 sampled
// - No action before ready flag asserted
// - Below fall threshold sets flag, acts
// - Clearing enable stops judging and actions
// - Above rise threshold clears flag, releases
// - CPU held 128 clocks after release
// - Settling and sampled judging frozen while tick stopped
// - Sampled mode uses tick-captured comparator values
// - Judging continues after ready until disabled
// - Action 00 none, 01/11 reset, 10 irq
// - Sample select: continuous or every 2 ticks
// - Enabling with mode 10/11 clears the undervoltage flag
// - Ready reads 0 when off or settling
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "svs_cfg.svh"
module svs_monitor (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic        slow_tick_16k_i,   // 16 kHz tick level, asynchronous
    input  wire logic        below_fall_i,      // Comparator: supply under fall threshold
    output logic [3:0]       fall_threshold_o,  // Threshold select to analog
    output logic             monitor_on_o,      // Analog enable
    output logic             uv_reset_o,        // Undervoltage reset request
    output logic             cpu_hold_o,        // CPU held in reset
    output logic             uv_irq_o,          // Undervoltage interrupt pulse
    output logic             irq_o,             // Level interrupt
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    logic [1:0]            sync_out;       // Tick and comparator, synchronised
    logic                  tick_q;         // Previous tick level
    logic                  tick_rise;      // One-cycle tick edge
    logic                  cmp_live;       // Synchronised comparator
    svs_pkg::svs_state_t   state;          // Supervision state
    svs_pkg::svs_state_t   next_state;
    logic [2:0]            tick_cnt;       // Settling tick counter
    logic [2:0]            next_tick_cnt;
    logic                  samp_phase;     // Every-second-tick phase
    logic                  next_samp_phase;
    logic                  cmp_sample;     // Comparator captured on tick
    logic                  next_cmp_sample;
    logic                  uv_flag;        // Undervoltage flag
    logic                  next_uv_flag;
    logic                  ready;          // Result valid flag
    logic [7:0]            hold_cnt;       // Post-release CPU hold count
    logic [7:0]            next_hold_cnt;
    logic                  monitor_enable; // Control register bit
    logic [3:0]            level;          // Threshold select field
    logic [1:0]            action_select;  // Action field
    logic                  sample_select;  // Sampling mode bit
    logic [1:0]            run_mode_sel;   // Running mode field
    logic [`SVS_IRQ_W-1:0] irq_stat;       // Sticky events
    logic [`SVS_IRQ_W-1:0] irq_en;         // Event enables
    logic [`SVS_IRQ_W-1:0] next_irq_stat;
    logic [`SVS_IRQ_W-1:0] events;         // Event pulses this cycle
    logic                  reset_act;      // Reset action selected
    logic                  irq_act;        // Interrupt action selected
    logic                  cmp_used;       // Comparator value judged
    logic                  aw_held;        // Write address captured
    logic                  w_held;         // Write data captured
    logic [11:0]           aw_addr;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  wr_fire;        // Both halves present
    logic [31:0]           rd_word;        // Read mux

    // Tick and comparator both come from outside the clock domain
    svs_sync #(
        .WIDTH (2)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .async_i   ({below_fall_i, slow_tick_16k_i}),
        .sync_o    (sync_out)
    );
    assign cmp_live  = sync_out[1];
    assign tick_rise = sync_out[0] & ~tick_q;

    // Action decode: 01 and 11 both mean reset
    assign reset_act = (action_select == svs_pkg::SVS_ACT_RST_A) ||
                       (action_select == svs_pkg::SVS_ACT_RST_B);
    assign irq_act   = (action_select == svs_pkg::SVS_ACT_IRQ);
    assign ready     = (state == svs_pkg::SVS_JUDGE);
    // Sampled mode only sees tick-captured values
    assign cmp_used  = sample_select ? cmp_sample : cmp_live;

    // Supervision sequencing and flag next state
    always_comb
    begin
        next_state      = state;
        next_tick_cnt   = tick_cnt;
        next_samp_phase = samp_phase;
        next_cmp_sample = cmp_sample;
        next_uv_flag    = uv_flag;
        case (state)
            svs_pkg::SVS_OFF:
            begin
                // Start only in supervisor running mode
                if (monitor_enable && run_mode_sel[1])
                begin
                    next_state      = svs_pkg::SVS_SETTLE;
                    next_tick_cnt   = '0;
                    next_samp_phase = 1'b0;
                    next_uv_flag    = 1'b0;
                end
            end
            svs_pkg::SVS_SETTLE:
            begin
                // Counter only moves on tick edges, frozen if tick stops
                if (tick_rise)
                begin
                    next_tick_cnt = tick_cnt + 3'h1;
                    if (sample_select)
                        next_cmp_sample = cmp_live;
                    if (tick_cnt + 3'h1 == 3'((sample_select ?
                        (`SVS_READY_TICKS + `SVS_SAMPLE_TICKS) : `SVS_READY_TICKS)))
                    begin
                        next_state   = svs_pkg::SVS_JUDGE;
                        // Flag stays masked until here; in sampled mode this
                        // tick's capture is the live value, so both modes agree
                        next_uv_flag = cmp_live;
                    end
                end
            end
            svs_pkg::SVS_JUDGE:
            begin
                // Sample every second tick in sampled mode
                if (tick_rise && sample_select)
                begin
                    next_samp_phase = ~samp_phase;
                    if (samp_phase)
                        next_cmp_sample = cmp_live;
                end
                // Continuous judging until disabled
                if (cmp_used)
                    next_uv_flag = 1'b1;
                else
                    next_uv_flag = 1'b0;
            end
            default:
                next_state = svs_pkg::SVS_OFF;
        endcase
        // Disable forces off and keeps the flag value
        if (!monitor_enable)
        begin
            next_state   = svs_pkg::SVS_OFF;
            next_uv_flag = uv_flag;
        end
    end

    // CPU hold counter after undervoltage reset
    always_comb
    begin
        next_hold_cnt = hold_cnt;
        if (uv_reset_o)
            next_hold_cnt = 8'(`SVS_RELEASE_CYC);
        else if (hold_cnt != 8'h00)
            next_hold_cnt = hold_cnt - 8'h01;
    end

    // Supervision registers
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state      <= svs_pkg::SVS_OFF;
            tick_cnt   <= 3'h0;
            samp_phase <= 1'b0;
            cmp_sample <= 1'b0;
            uv_flag    <= 1'b0;
            hold_cnt   <= 8'h00;
            tick_q     <= 1'b0;
            uv_reset_o <= 1'b0;
            uv_irq_o   <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            tick_cnt   <= next_tick_cnt;
            samp_phase <= next_samp_phase;
            cmp_sample <= next_cmp_sample;
            uv_flag    <= next_uv_flag;
            hold_cnt   <= next_hold_cnt;
            tick_q     <= sync_out[0];
            // Actions only once ready and enabled
            uv_reset_o <= (next_state == svs_pkg::SVS_JUDGE) && next_uv_flag && reset_act;
            uv_irq_o   <= (next_state == svs_pkg::SVS_JUDGE) && next_uv_flag && !uv_flag
                          && irq_act;
        end
    end

    assign cpu_hold_o       = uv_reset_o || (hold_cnt != 8'h00);
    assign monitor_on_o     = monitor_enable;
    assign fall_threshold_o = level;

    // Events: undervoltage entry, recovery, ready
    // Entry also counts on the ready cycle, when the flag may rise at once
    assign events[`SVS_IRQ_UV_FALL] = next_uv_flag && !uv_flag
                                      && (next_state == svs_pkg::SVS_JUDGE);
    assign events[`SVS_IRQ_UV_RISE] = !next_uv_flag && uv_flag && ready;
    assign events[`SVS_IRQ_READY]   = (next_state == svs_pkg::SVS_JUDGE) && !ready;

    // Sticky status: a set in the clear cycle wins
    always_comb
    begin
        next_irq_stat = irq_stat;
        if (wr_fire && aw_addr == `SVS_IRQ_CLR_OFF && w_strb[0])
            next_irq_stat = irq_stat & ~w_data[`SVS_IRQ_W-1:0];
        next_irq_stat = next_irq_stat | events;
    end
    assign irq_o = |(irq_stat & irq_en);

    // AXI write channel: address and data accepted in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire       = aw_held && w_held;
    assign s_axi_bresp   = 2'h0;
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp   = 2'h0;

    // Read mux, unmapped reads as zero with OKAY
    always_comb
    begin
        rd_word = `SVS_RESET_VAL;
        case (s_axi_araddr)
            `SVS_CTRL_OFF:
            begin
                rd_word[`SVS_LEVEL_W-1:0]  = level;
                rd_word[`SVS_CTRL_EN_BIT]  = monitor_enable;
                rd_word[`SVS_CTRL_UV_BIT]  = uv_flag;
                rd_word[`SVS_CTRL_RV_BIT]  = ready;
            end
            `SVS_MODE_OFF:
            begin
                rd_word[1:0]                                = action_select;
                rd_word[`SVS_MODE_SS_BIT]                   = sample_select;
                rd_word[`SVS_MODE_RM_LSB+1:`SVS_MODE_RM_LSB] = run_mode_sel;
            end
            `SVS_IRQ_STAT_OFF: rd_word[`SVS_IRQ_W-1:0] = irq_stat;
            `SVS_IRQ_EN_OFF:   rd_word[`SVS_IRQ_W-1:0] = irq_en;
            default:           rd_word = `SVS_RESET_VAL;
        endcase
    end

    // Bus and register state
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
            aw_addr        <= 12'h000;
            w_data         <= 32'h0000_0000;
            w_strb         <= 4'h0;
            s_axi_bvalid   <= 1'b0;
            s_axi_rvalid   <= 1'b0;
            s_axi_rdata    <= 32'h0000_0000;
            monitor_enable <= 1'b0;
            level          <= 4'h0;
            action_select  <= 2'h0;
            sample_select  <= 1'b0;
            run_mode_sel   <= 2'h0;
            irq_stat       <= '0;
            irq_en         <= '0;
        end
        else
        begin
            irq_stat <= next_irq_stat;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    `SVS_CTRL_OFF:
                    begin
                        if (w_strb[0])
                            level <= w_data[`SVS_LEVEL_W-1:0];
                        if (w_strb[1])
                            monitor_enable <= w_data[`SVS_CTRL_EN_BIT];
                    end
                    `SVS_MODE_OFF:
                    begin
                        if (w_strb[0])
                            action_select <= w_data[1:0];
                        if (w_strb[1])
                        begin
                            sample_select <= w_data[`SVS_MODE_SS_BIT];
                            run_mode_sel  <= w_data[`SVS_MODE_RM_LSB+1:`SVS_MODE_RM_LSB];
                        end
                    end
                    `SVS_IRQ_EN_OFF:
                        if (w_strb[0])
                            irq_en <= w_data[`SVS_IRQ_W-1:0];
                    default:
                        aw_held <= 1'b0;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // No reset or interrupt action while not ready
    no_early_rst_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        uv_reset_o || uv_irq_o |-> ready) else $error("action before ready");
    // Enabling from off with mode 10/11 clears the flag
    enable_clear_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (state == svs_pkg::SVS_OFF && monitor_enable && run_mode_sel[1])
        |=> !uv_flag) else $error("flag not cleared on enable");
    // Disable returns to off next cycle
    disable_off_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !monitor_enable |=> !ready && !uv_reset_o) else $error("active when off");
    // Hold lasts at least 8 cycles after the reset request falls
    hold_len_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        $fell(uv_reset_o) |-> cpu_hold_o [*8]) else $error("hold too short");
    // Flag stays masked while settling
    mask_settle_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        state == svs_pkg::SVS_SETTLE && $past(state) == svs_pkg::SVS_SETTLE
        |-> !uv_flag) else $error("flag during settle");
    // Settling counter never moves without tick
    tick_freeze_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        state == svs_pkg::SVS_SETTLE && !tick_rise && monitor_enable
        |=> $stable(tick_cnt)) else $error("count moved without tick");
    // Undervoltage in judge sets flag next cycle
    uv_set_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        ready && monitor_enable && cmp_used |=> uv_flag) else $error("flag not set");
    // Recovery clears flag and reset
    uv_clear_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        ready && monitor_enable && !cmp_used |=> !uv_flag && !uv_reset_o)
        else $error("flag not cleared");
    // Interrupt only when interrupt action chosen
    irq_sel_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        uv_irq_o |-> $past(irq_act)) else $error("irq with wrong action");
    // Only supervisor running modes start
    mode_gate_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        state == svs_pkg::SVS_OFF && !run_mode_sel[1] |=> state == svs_pkg::SVS_OFF)
        else $error("started in bad mode");
endmodule

// ---- testbench/svs_analog_model.sv ----
// Behavioural model of the supply comparator and the slow tick source
`timescale 1ns/1ps
module svs_analog_model #(
    parameter int TICK_HALF = 20        // Shortened tick half period, in clock cycles
) (
    input  wire logic ref_clk_i,
    input  wire logic tick_run_i,       // Tick source running
    input  wire logic supply_low_i,     // Supply profile: under the fall threshold
    output logic      slow_tick_16k_o = 1'h0,
    output logic      below_fall_o = 1'h0
);
    int cnt = 0;                        // Cycles into the current half period

    // Tick stands low while stopped, so a halted source makes no rising edge
    always @(posedge ref_clk_i)
    begin
        if (!tick_run_i)
        begin
            cnt <= 0;
            slow_tick_16k_o <= 1'h0;
        end
        else if (cnt == TICK_HALF - 1)
        begin
            cnt <= 0;
            slow_tick_16k_o <= ~slow_tick_16k_o;
        end
        else
            cnt <= cnt + 1;
    end

    // Comparator settles a few ns late; hysteresis lives in the supply profile
    always @(supply_low_i)
        below_fall_o <= #3 supply_low_i;
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the supply monitor controller
`timescale 1ns/1ps
`include "svs_cfg.svh"
module tb_top;
    logic        ref_clk_i = 1'h0, reset_i = 1'h1;
    logic        tick_run = 1'h0, supply_low = 1'h0;   // Partner controls
    logic        slow_tick_16k_i, below_fall_i;
    logic [3:0]  fall_threshold_o;
    logic        monitor_on_o, uv_reset_o, cpu_hold_o, uv_irq_o, irq_o;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;                    // Full words only
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          errors = 0, n_compared = 0, cyc = 0;
    int          ticks = 0, pulses = 0;                 // Tick edges, irq pulses seen

    svs_analog_model #(.TICK_HALF(20)) model (.ref_clk_i, .tick_run_i(tick_run),
        .supply_low_i(supply_low), .slow_tick_16k_o(slow_tick_16k_i),
        .below_fall_o(below_fall_i));
    svs_monitor dut (.ref_clk_i, .reset_i, .slow_tick_16k_i, .below_fall_i, .fall_threshold_o,
        .monitor_on_o, .uv_reset_o, .cpu_hold_o, .uv_irq_o, .irq_o, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge slow_tick_16k_i) ticks++;
    always @(posedge ref_clk_i) if (uv_irq_o === 1'h1) pulses++;
    // Hang guard, far above the roughly 1200 cycles the run needs
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Pins are looked at on the falling edge, where registers have settled
    task automatic pin(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    // Address and data offered together; handshakes judged on the value before the edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, da, dw;
        da = 1'h0;
        dw = 1'h0;
        @(posedge ref_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(da && dw))
        begin
            @(negedge ref_clk_i);
            ta = !da && s_axi_awready === 1'h1;
            tw = !dw && s_axi_wready === 1'h1;
            @(posedge ref_clk_i);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            da = da | ta;
            dw = dw | tw;
        end
        do @(negedge ref_clk_i); while (s_axi_bvalid !== 1'h1);
        chk(32'(s_axi_bresp), 32'h0);
        @(posedge ref_clk_i);
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(negedge ref_clk_i); while (s_axi_arready !== 1'h1);
        @(posedge ref_clk_i);
        s_axi_arvalid <= 1'h0;
        do @(negedge ref_clk_i); while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        chk(32'(s_axi_rresp), 32'h0);
        @(posedge ref_clk_i);
        s_axi_rready <= 1'h0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask

    // Wait for n more tick edges, then past the synchroniser latency
    task automatic tk(input int n);
        int t;
        t = ticks + n;
        wait (ticks >= t);
        repeat (10) @(posedge ref_clk_i);
    endtask

    task automatic sup(input logic l);
        @(posedge ref_clk_i);
        supply_low <= l;
    endtask

    initial
    begin
        logic [31:0] n;
        repeat (10) @(posedge ref_clk_i);
        reset_i <= 1'h0;
        // Reset values, an unmapped place, a read-only status
        for (int i = 0; i < 5; i++)
            rdchk(i == 4 ? 12'h100 : 12'(i * 4), `SVS_RESET_VAL);
        wr(`SVS_IRQ_STAT_OFF, 32'hffff_ffff);
        rdchk(`SVS_IRQ_STAT_OFF, 32'h0);
        // Reset action, continuous; supply already low when enabled
        wr(`SVS_MODE_OFF, 32'h0000_0401);
        sup(1'h1);
        wr(`SVS_CTRL_OFF, 32'h0000_0103);
        repeat (300) @(posedge ref_clk_i);
        rdchk(`SVS_CTRL_OFF, 32'h0000_0103);
        @(negedge ref_clk_i);
        pin(uv_reset_o, 1'h0);
        pin(monitor_on_o, 1'h1);
        chk(32'(fall_threshold_o), 32'h3);
        @(posedge ref_clk_i);
        tick_run <= 1'h1;
        tk(3);
        rdchk(`SVS_CTRL_OFF, 32'h0000_0103);
        tk(1);
        rdchk(`SVS_CTRL_OFF, 32'h0000_0703);
        @(negedge ref_clk_i);
        pin(uv_reset_o, 1'h1);
        pin(cpu_hold_o, 1'h1);
        sup(1'h0);
        do @(negedge ref_clk_i); while (uv_reset_o !== 1'h0);
        n = 0;
        while (cpu_hold_o === 1'h1)
        begin
            n++;
            @(negedge ref_clk_i);
        end
        chk(n, 32'd128);
        rdchk(`SVS_CTRL_OFF, 32'h0000_0503);
        sup(1'h1);
        repeat (10) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        pin(uv_reset_o, 1'h1);
        chk(pulses, 0);
        wr(`SVS_CTRL_OFF, 32'h0000_0003);
        repeat (5) @(negedge ref_clk_i);
        pin(uv_reset_o, 1'h0);
        pin(monitor_on_o, 1'h0);
        rdchk(`SVS_CTRL_OFF, 32'h0000_0203);
        // Interrupt action, sampled; entry interrupt armed before enabling
        tick_run <= 1'h0;
        wr(`SVS_IRQ_CLR_OFF, 32'h7);
        wr(`SVS_IRQ_EN_OFF, 32'h1);
        wr(`SVS_MODE_OFF, 32'h0000_0702);
        wr(`SVS_CTRL_OFF, 32'h0000_0105);
        rdchk(`SVS_CTRL_OFF, 32'h0000_0105);
        @(posedge ref_clk_i);
        tick_run <= 1'h1;
        tk(5);
        rdchk(`SVS_CTRL_OFF, 32'h0000_0105);
        tk(1);
        rdchk(`SVS_CTRL_OFF, 32'h0000_0705);
        @(negedge ref_clk_i);
        pin(irq_o, 1'h1);
        pin(uv_reset_o, 1'h0);
        chk(pulses, 1);
        // Supply recovers just after a tick: flag waits for a sampled value
        @(posedge slow_tick_16k_i);
        repeat (5) @(posedge ref_clk_i);
        supply_low <= 1'h0;
        repeat (25) @(posedge ref_clk_i);
        rdchk(`SVS_CTRL_OFF, 32'h0000_0705);
        tk(2);
        rdchk(`SVS_CTRL_OFF, 32'h0000_0505);
        // A dip between samples is never seen
        @(posedge slow_tick_16k_i);
        repeat (5) @(posedge ref_clk_i);
        supply_low <= 1'h1;
        repeat (20) @(posedge ref_clk_i);
        supply_low <= 1'h0;
        tk(2);
        rdchk(`SVS_CTRL_OFF, 32'h0000_0505);
        // Sticky events, masking and clearing
        rdchk(`SVS_IRQ_STAT_OFF, 32'h7);
        wr(`SVS_IRQ_EN_OFF, 32'h0);
        @(negedge ref_clk_i);
        pin(irq_o, 1'h0);
        wr(`SVS_IRQ_EN_OFF, 32'h2);
        rdchk(`SVS_IRQ_EN_OFF, 32'h2);
        @(negedge ref_clk_i);
        pin(irq_o, 1'h1);
        wr(`SVS_IRQ_CLR_OFF, 32'h7);
        rdchk(`SVS_IRQ_STAT_OFF, 32'h0);
        @(negedge ref_clk_i);
        pin(irq_o, 1'h0);
        wr(`SVS_CTRL_OFF, 32'h0);
        close_out();
    end
endmodule
